/* File: inc/ocm_consts.vh */
`ifndef OCM_CONSTS_VH
`define OCM_CONSTS_VH

// ----------------------------------------
// Register address width and offsets (byte addresses)
// ----------------------------------------
`define OCM_AXI_AW      12
`define OCM_OFS_CTRL    12'h000
`define OCM_OFS_STAT    12'h004
`define OCM_OFS_DADDR   12'h008
`define OCM_OFS_DDATA   12'h00c

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define OCM_CTRL_DBG_WE 0
`define OCM_CTRL_AINC   1
`define OCM_CTRL_RST    2'h0
`define OCM_STAT_PROT   0
`define OCM_STAT_DROP   1
`define OCM_STAT_DBG    2
`define OCM_RESP_OKAY   2'h0
`define OCM_RESP_SLVERR 2'h2

// ----------------------------------------
// Configuration codes
// ----------------------------------------
`define OCM_PORT_SINGLE 2'h0
`define OCM_PORT_DUAL   2'h1
`define OCM_PORT_SIMPLE 2'h2
`define OCM_BLK_AUTO    2'h0
`define OCM_BLK_LARGE   2'h1
`define OCM_BLK_LOGIC   2'h2
`define OCM_RDW_UNSPEC  2'h0
`define OCM_RDW_OLD     2'h1
`define OCM_RDW_NEW     2'h2

`endif

/* File: verilog/ocm_ram.v */
// What this block does
// - RAM reads and writes; ROM ignores writes
// - Single-port mode exposes one agent port
// - True dual-port: both ports read and write
// - Simple dual: port one writes, two reads
// - ROM builds with one or two read ports
// - Debug path may write ROM contents
// - Two ports share one clock source
// - Auto enable: output capture clocked only on access
// - Port widths 8 to 1024, may differ
// - Logic-array type: no true dual, same widths
// - Mixed read-during-write follows chosen mode
// - Mixed mode only for single-clock RAM
// - Large/auto blocks: unspecified or old only
// - Logic-array simple dual needs inner stage
// - Inner output stage adds one cycle
// - Outer output stage adds one more cycle
// - Reset request gates memory clock off
// - Contents hold initial value at power-up
// - Reconfig option adds clock-enable qualifier
// - Register path reads and writes the array
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "ocm_consts.vh"

module ocm_ram #(
	parameter       IS_ROM     = 0,
	parameter [1:0] PORT_MODE  = `OCM_PORT_SINGLE,
	parameter [1:0] BLOCK_TYPE = `OCM_BLK_AUTO,
	parameter       SINGLE_CLK = 1,
	parameter [1:0] RDW_MODE   = `OCM_RDW_UNSPEC,
	parameter       AUTO_CE    = 0,
	parameter       MIXED_W    = 0,
	parameter       DW_A       = 32,
	parameter       DW_B       = 32,
	parameter       WB         = (MIXED_W && BLOCK_TYPE != `OCM_BLK_LOGIC) ? DW_B : DW_A,
	parameter       MEM_BYTES  = 4096,
	parameter       L1_A       = 0,
	parameter       L2_A       = 0,
	parameter       L1_B       = 0,
	parameter       L2_B       = 0,
	parameter       PROTECT    = 0,
	parameter       INIT_EN    = 0,
	parameter [7:0] INIT_BYTE  = 8'h00,
	parameter       PR_EN      = 0,
	parameter       DBG_PORT   = 0,
	parameter       EDIT_EN    = 0,
	parameter       AW_A       = 10,
	parameter       AW_B       = 10
) (
	input  wire                       aclk,
	input  wire                       aresetn,
	input  wire                       reset_req,
	input  wire [AW_A-1:0]            a_addr,
	input  wire                       a_read,
	input  wire                       a_write,
	input  wire [DW_A/8-1:0]          a_byteen,
	input  wire [DW_A-1:0]            a_wdata,
	output wire [DW_A-1:0]            a_rdata,
	output wire                       a_rvalid,
	input  wire [AW_B-1:0]            b_addr,
	input  wire                       b_read,
	input  wire                       b_write,
	input  wire [WB/8-1:0]            b_byteen,
	input  wire [WB-1:0]              b_wdata,
	output wire [WB-1:0]              b_rdata,
	output wire                       b_rvalid,
	input  wire [`OCM_AXI_AW-1:0]     s_axi_awaddr,
	input  wire                       s_axi_awvalid,
	output wire                       s_axi_awready,
	input  wire [31:0]                s_axi_wdata,
	input  wire [3:0]                 s_axi_wstrb,
	input  wire                       s_axi_wvalid,
	output wire                       s_axi_wready,
	output wire [1:0]                 s_axi_bresp,
	output wire                       s_axi_bvalid,
	input  wire                       s_axi_bready,
	input  wire [`OCM_AXI_AW-1:0]     s_axi_araddr,
	input  wire                       s_axi_arvalid,
	output wire                       s_axi_arready,
	output wire [31:0]                s_axi_rdata,
	output wire [1:0]                 s_axi_rresp,
	output wire                       s_axi_rvalid,
	input  wire                       s_axi_rready
);

	// ----------------------------------------
	// Effective configuration
	// ----------------------------------------
	function integer clog2;
		input integer v;
		integer n;
		begin
			n = 0;
			while ((1 << n) < v)
				n = n + 1;
			clog2 = (n < 1) ? 1 : n;
		end
	endfunction

	localparam LAB  = (BLOCK_TYPE == `OCM_BLK_LOGIC);
	// Logic-array blocks cannot do true dual, so fall back to simple
	localparam [1:0] MODE = IS_ROM ?
		((PORT_MODE == `OCM_PORT_SIMPLE) ? `OCM_PORT_DUAL : PORT_MODE) :
		((LAB && PORT_MODE == `OCM_PORT_DUAL) ? `OCM_PORT_SIMPLE : PORT_MODE);
	// Lanes per port word; any whole-byte width from 8 to 1024 bits
	localparam NB_A = DW_A / 8;
	localparam NB_B = WB / 8;
	localparam BA_W = clog2(MEM_BYTES);
	localparam A_WR = !IS_ROM;
	localparam A_RD = (MODE != `OCM_PORT_SIMPLE);
	localparam B_WR = !IS_ROM && (MODE == `OCM_PORT_DUAL);
	localparam B_RD = (MODE != `OCM_PORT_SINGLE);
	localparam DBG_OK = (IS_ROM && DBG_PORT) || EDIT_EN;
	// Mixed-port result narrowed to what the block type can give
	localparam [1:0] RDW =
		(IS_ROM || !SINGLE_CLK) ? `OCM_RDW_UNSPEC :
		(LAB && L1_B == 0) ? `OCM_RDW_UNSPEC :
		(!LAB && RDW_MODE == `OCM_RDW_NEW) ? `OCM_RDW_OLD :
		RDW_MODE;

	function [BA_W-1:0] bidx;
		input [31:0] w;
		input [31:0] i;
		input [31:0] nb;
		reg   [31:0] t;
		begin
			t = w * nb + i;
			bidx = t[BA_W-1:0];
		end
	endfunction

	// ----------------------------------------
	// Storage and enables
	// ----------------------------------------
	reg  [7:0]      mem [0:MEM_BYTES-1];
	reg             pr_ok_q;
	reg  [1:0]      ctrl_q;
	reg  [BA_W-1:0] dbg_addr_q;
	reg  [31:0]     s_axi_wdata_q;
	wire            dbg_we;
	integer         k;

	// Unspecified mixed reads return old contents in this model
	initial begin
		for (k = 0; k < MEM_BYTES; k = k + 1)
			mem[k] = INIT_EN ? INIT_BYTE : 8'h00;
	end

	// Word addresses widened once for the byte index
	wire [31:0] a_addr32 = {{(32-AW_A){1'b0}}, a_addr};
	wire [31:0] b_addr32 = {{(32-AW_B){1'b0}}, b_addr};
	wire prot    = PROTECT && reset_req;
	wire ce_base = !prot && (!PR_EN || pr_ok_q);
	wire wr_a    = A_WR && a_write && ce_base;
	wire rd_a    = A_RD && a_read && ce_base;
	wire wr_b    = B_WR && b_write && ce_base;
	wire rd_b    = B_RD && b_read && ce_base;
	// Output capture frozen while idle saves power, holds last data
	wire cap_a   = A_RD && ce_base && (!AUTO_CE || a_read || a_write);
	wire cap_b   = B_RD && ce_base && (!AUTO_CE || b_read || b_write);

	always @(posedge aclk) begin
		if (!aresetn)
			pr_ok_q <= 1'b0;
		else
			pr_ok_q <= 1'b1;
	end

	// Port one written last so it wins a same-byte clash
	integer i;
	always @(posedge aclk) begin
		if (dbg_we)
			mem[dbg_addr_q] <= s_axi_wdata_q[7:0];
		for (i = 0; i < NB_B; i = i + 1)
			if (wr_b && b_byteen[i])
				mem[bidx(b_addr32, i, NB_B)] <= b_wdata[8*i +: 8];
		for (i = 0; i < NB_A; i = i + 1)
			if (wr_a && a_byteen[i])
				mem[bidx(a_addr32, i, NB_A)] <= a_wdata[8*i +: 8];
	end

	// ----------------------------------------
	// Array read with mixed-port bypass
	// ----------------------------------------
	reg [DW_A-1:0] rd_a_d;
	reg [WB-1:0]   rd_b_d;
	reg [BA_W-1:0] ix;
	integer        j;
	integer        kk;

	// Wide words overlay narrow ones, lowest byte first
	always @* begin
		rd_a_d = {DW_A{1'b0}};
		rd_b_d = {WB{1'b0}};
		ix = {BA_W{1'b0}};
		kk = 0;
		for (j = 0; j < NB_A; j = j + 1) begin
			ix = bidx(a_addr32, j, NB_A);
			kk = ix;
			rd_a_d[8*j +: 8] = mem[ix];
			if (RDW == `OCM_RDW_NEW && wr_b && (kk / NB_B) == b_addr32 &&
			    b_byteen[kk % NB_B])
				rd_a_d[8*j +: 8] = b_wdata[8*(kk % NB_B) +: 8];
		end
		for (j = 0; j < NB_B; j = j + 1) begin
			ix = bidx(b_addr32, j, NB_B);
			kk = ix;
			rd_b_d[8*j +: 8] = mem[ix];
			if (RDW == `OCM_RDW_NEW && wr_a && (kk / NB_A) == a_addr32 &&
			    a_byteen[kk % NB_A])
				rd_b_d[8*j +: 8] = a_wdata[8*(kk % NB_A) +: 8];
		end
	end

	// ----------------------------------------
	// Read pipelines
	// ----------------------------------------
	reg [DW_A-1:0] a_s0_q, a_s1_q, a_s2_q;
	reg [WB-1:0]   b_s0_q, b_s1_q, b_s2_q;
	reg [2:0]      a_v_q, b_v_q;

	// Both ports run on aclk; no second clock domain exists here
	always @(posedge aclk) begin
		if (!aresetn) begin
			a_s0_q <= {DW_A{1'b0}};
			a_s1_q <= {DW_A{1'b0}};
			a_s2_q <= {DW_A{1'b0}};
			b_s0_q <= {WB{1'b0}};
			b_s1_q <= {WB{1'b0}};
			b_s2_q <= {WB{1'b0}};
			a_v_q  <= 3'h0;
			b_v_q  <= 3'h0;
		end else begin
			if (cap_a)
				a_s0_q <= rd_a_d;
			if (cap_b)
				b_s0_q <= rd_b_d;
			a_s1_q <= a_s0_q;
			b_s1_q <= b_s0_q;
			a_s2_q <= L1_A ? a_s1_q : a_s0_q;
			b_s2_q <= L1_B ? b_s1_q : b_s0_q;
			a_v_q[0] <= rd_a;
			b_v_q[0] <= rd_b;
			a_v_q[1] <= a_v_q[0];
			b_v_q[1] <= b_v_q[0];
			a_v_q[2] <= L1_A ? a_v_q[1] : a_v_q[0];
			b_v_q[2] <= L1_B ? b_v_q[1] : b_v_q[0];
		end
	end

	// Latency is one plus each enabled stage
	assign a_rdata  = L2_A ? a_s2_q : (L1_A ? a_s1_q : a_s0_q);
	assign b_rdata  = L2_B ? b_s2_q : (L1_B ? b_s1_q : b_s0_q);
	assign a_rvalid = L2_A ? a_v_q[2] : (L1_A ? a_v_q[1] : a_v_q[0]);
	assign b_rvalid = L2_B ? b_v_q[2] : (L1_B ? b_v_q[1] : b_v_q[0]);

	// ----------------------------------------
	// AXI4-Lite register slave
	// ----------------------------------------
	reg                   aw_have_q;
	reg                   w_have_q;
	reg [`OCM_AXI_AW-1:0] awaddr_q;
	reg [3:0]             wstrb_q;
	reg                   bvalid_q;
	reg [1:0]             bresp_q;
	reg                   rvalid_q;
	reg [1:0]             rresp_q;
	reg [31:0]            rdata_q;
	reg                   drop_q;
	reg [31:0]            rd_word;

	// A response not yet taken stalls the next commit
	wire commit = aw_have_q && w_have_q && !bvalid_q;
	wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
		{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	wire [31:0] ctrl32 = {30'h0, ctrl_q};
	wire [31:0] daddr32 = {{(32-BA_W){1'b0}}, dbg_addr_q};
	wire [31:0] ctrl_new = (ctrl32 & ~wmask) | (s_axi_wdata_q & wmask);
	wire [31:0] daddr_new = (daddr32 & ~wmask) | (s_axi_wdata_q & wmask);
	wire hit_w = (awaddr_q == `OCM_OFS_CTRL) || (awaddr_q == `OCM_OFS_STAT) ||
		(awaddr_q == `OCM_OFS_DADDR) || (awaddr_q == `OCM_OFS_DDATA);
	wire dd_w = commit && awaddr_q == `OCM_OFS_DDATA && wstrb_q[0];
	// Gated by the software unlock and by the memory enable
	assign dbg_we = dd_w && DBG_OK && ctrl_q[`OCM_CTRL_DBG_WE] && ce_base;
	wire drop_clr = commit && awaddr_q == `OCM_OFS_STAT && wstrb_q[0] &&
		s_axi_wdata_q[`OCM_STAT_DROP];

	always @* begin
		rd_word = 32'h0;
		case (s_axi_araddr)
			`OCM_OFS_CTRL:  rd_word = ctrl32;
			`OCM_OFS_STAT:  rd_word = {29'h0, DBG_OK != 0, drop_q, prot};
			`OCM_OFS_DADDR: rd_word = daddr32;
			`OCM_OFS_DDATA: rd_word = DBG_OK ? {24'h0, mem[dbg_addr_q]} : 32'h0;
			default:        rd_word = 32'h0;
		endcase
	end

	wire hit_r = (s_axi_araddr == `OCM_OFS_CTRL) ||
		(s_axi_araddr == `OCM_OFS_STAT) ||
		(s_axi_araddr == `OCM_OFS_DADDR) ||
		(s_axi_araddr == `OCM_OFS_DDATA);

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			awaddr_q      <= {`OCM_AXI_AW{1'b0}};
			s_axi_wdata_q <= 32'h0;
			wstrb_q       <= 4'h0;
			bvalid_q      <= 1'b0;
			bresp_q       <= `OCM_RESP_OKAY;
			rvalid_q      <= 1'b0;
			rresp_q       <= `OCM_RESP_OKAY;
			rdata_q       <= 32'h0;
			ctrl_q        <= `OCM_CTRL_RST;
			dbg_addr_q    <= {BA_W{1'b0}};
			drop_q        <= 1'b0;
		end else begin
			if (s_axi_awvalid && !aw_have_q) begin
				aw_have_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_have_q) begin
				w_have_q      <= 1'b1;
				s_axi_wdata_q <= s_axi_wdata;
				wstrb_q       <= s_axi_wstrb;
			end
			if (commit) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= hit_w ? `OCM_RESP_OKAY : `OCM_RESP_SLVERR;
				if (awaddr_q == `OCM_OFS_CTRL)
					ctrl_q <= ctrl_new[1:0];
				if (awaddr_q == `OCM_OFS_DADDR)
					dbg_addr_q <= daddr_new[BA_W-1:0];
			end else if (s_axi_bready && bvalid_q) begin
				bvalid_q <= 1'b0;
			end
			if (dbg_we && ctrl_q[`OCM_CTRL_AINC])
				dbg_addr_q <= dbg_addr_q + 1'b1;
			// Set beats clear when both land together
			if (dd_w && !dbg_we)
				drop_q <= 1'b1;
			else if (drop_clr)
				drop_q <= 1'b0;
			// Read address sampled at the edge it is taken
			if (s_axi_arvalid && !rvalid_q) begin
				rvalid_q <= 1'b1;
				rdata_q  <= rd_word;
				rresp_q  <= hit_r ? `OCM_RESP_OKAY : `OCM_RESP_SLVERR;
			end else if (s_axi_rready && rvalid_q) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// Ready only while the holding slot is empty
	assign s_axi_awready = !aw_have_q;
	assign s_axi_wready  = !w_have_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

endmodule

/* File: verif/ocm_ram_checker.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Agent port and register bus checks
// ----------------------------------------
module ocm_ram_checker #(
	parameter AW_A = 10,
	parameter DW_A = 32,
	parameter L1_A = 0,
	parameter L2_A = 0,
	parameter L1_B = 0,
	parameter L2_B = 0
) (
	input logic              aclk,
	input logic              aresetn,
	input logic              reset_req,
	input logic [AW_A-1:0]   a_addr,
	input logic              a_read,
	input logic              a_write,
	input logic [DW_A/8-1:0] a_byteen,
	input logic [DW_A-1:0]   a_wdata,
	input logic [DW_A-1:0]   a_rdata,
	input logic              a_rvalid,
	input logic              b_read,
	input logic              b_write,
	input logic              b_rvalid,
	input logic              s_axi_awvalid,
	input logic              s_axi_awready,
	input logic              s_axi_wvalid,
	input logic              s_axi_wready,
	input logic [1:0]        s_axi_bresp,
	input logic              s_axi_bvalid,
	input logic              s_axi_bready,
	input logic              s_axi_arvalid,
	input logic              s_axi_arready,
	input logic [31:0]       s_axi_rdata,
	input logic              s_axi_rvalid,
	input logic              s_axi_rready
);
	localparam int LA = 1 + L1_A + L2_A;
	localparam int LB = 1 + L1_B + L2_B;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_A_LAT: assert property (a_read && !reset_req |-> ##LA a_rvalid)
		else $error("port one read not answered on time");
	AST_A_SRC: assert property (a_rvalid |-> $past(a_read, LA) && !$past(reset_req, LA))
		else $error("port one answer without a matching read");
	AST_B_LAT: assert property (b_read && !reset_req |-> ##LB b_rvalid)
		else $error("port two read not answered on time");
	AST_RAW: assert property ((a_write && &a_byteen && !reset_req) ##1 (a_read && !a_write
		&& !b_write && !reset_req && a_addr == $past(a_addr)) |-> ##LA a_rdata == $past(a_wdata, LA + 1))
		else $error("port one read missed the word just written");
	AST_GATE: assert property (reset_req && a_read |-> ##LA !a_rvalid)
		else $error("read answered while memory gated");
	AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response dropped before taken");
	AST_AR: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("register read answer late");
	AST_AW: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid)
		else $error("register write answer late");
endmodule

bind ocm_ram ocm_ram_checker #(.AW_A(AW_A), .DW_A(DW_A), .L1_A(L1_A), .L2_A(L2_A),
	.L1_B(L1_B), .L2_B(L2_B)) u_chk (.aclk, .aresetn, .reset_req, .a_addr, .a_read, .a_write,
	.a_byteen, .a_wdata, .a_rdata, .a_rvalid, .b_read, .b_write, .b_rvalid, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

/* File: verif/ocm_host.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Host on port two
// ----------------------------------------
module ocm_host (
	input  logic        aclk,
	input  logic        go,
	input  logic        wr,
	input  logic [9:0]  addr,
	input  logic [31:0] wdata,
	output logic [9:0]  b_addr = 10'h000,
	output logic        b_read = 1'b0,
	output logic        b_write = 1'b0,
	output logic [3:0]  b_byteen = 4'h0,
	output logic [31:0] b_wdata = 32'h0,
	input  logic [31:0] b_rdata,
	input  logic        b_rvalid,
	output logic        got = 1'b0,
	output logic [31:0] rd_data = 32'h0
);
	// Idle address, data and byte enables keep toggling so nothing leans on stale values
	always @(posedge aclk) begin
		b_read <= go && !wr;
		b_write <= go && wr;
		b_addr <= go ? addr : ~b_addr;
		b_wdata <= go ? wdata : ~b_wdata;
		b_byteen <= go ? 4'hf : ~b_byteen;
		got <= b_rvalid;
		if (b_rvalid)
			rd_data <= b_rdata;
	end
endmodule

/* File: verif/test_ocm_ram.sv */
`timescale 1ns/1ps
`include "ocm_consts.vh"
`define chk(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin err_total++; \
	$display("unexpected %s: expected %h seen %h", nm, exp, got); end end

module test_ocm_ram;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic reset_req = 1'b0;
	logic [9:0] a_addr = 10'h000;
	logic a_read = 1'b0;
	logic a_write = 1'b0;
	logic [3:0] a_byteen = 4'h0;
	logic [31:0] a_wdata = 32'h0;
	wire [31:0] a_rdata, b_wdata, b_rdata, h_data, s_axi_rdata;
	wire [9:0] b_addr;
	wire [3:0] b_byteen;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire a_rvalid, b_read, b_write, b_rvalid, h_got;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic h_go = 1'b0;
	logic h_wr = 1'b0;
	logic [9:0] h_addr = 10'h000;
	logic [31:0] h_wd = 32'h0;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic [11:0] s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	int err_total = 0, total_checks = 0, cycles = 0;
	logic [31:0] q;
	logic [1:0] r;
	logic hit;
	// Rows: writing port, word address, data read back on the other port
	logic row_wp [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
	logic [9:0] row_ad [4] = '{10'h000, 10'h3ff, 10'h155, 10'h2aa};
	logic [31:0] row_d [4] = '{32'h0123_4567, 32'hfedc_ba98, 32'ha5a5_5a5a, 32'h8000_0001};

	always #2.5 aclk = ~aclk;

	ocm_ram #(.PORT_MODE(`OCM_PORT_DUAL), .RDW_MODE(`OCM_RDW_OLD), .L1_A(1), .L1_B(1),
		.L2_B(1), .PROTECT(1), .EDIT_EN(1)) dut (.aclk, .aresetn, .reset_req, .a_addr, .a_read,
		.a_write, .a_byteen, .a_wdata, .a_rdata, .a_rvalid, .b_addr, .b_read, .b_write,
		.b_byteen, .b_wdata, .b_rdata, .b_rvalid, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	ocm_host u_host (.aclk, .go(h_go), .wr(h_wr), .addr(h_addr), .wdata(h_wd), .b_addr,
		.b_read, .b_write, .b_byteen, .b_wdata, .b_rdata, .b_rvalid, .got(h_got), .rd_data(h_data));

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	// A write leaves its strobe up so a following read lands back to back
	task automatic a_op(input logic wr, input logic [9:0] ad, input logic [31:0] d);
		@(posedge aclk);
		a_read <= !wr;
		a_write <= wr;
		a_addr <= ad;
		a_wdata <= d;
		a_byteen <= 4'hf;
		if (!wr) begin
			@(posedge aclk);
			a_read <= 1'b0;
			repeat (8) begin
				@(negedge aclk);
				if (a_rvalid) break;
			end
			q = a_rdata;
			hit = a_rvalid;
		end
	endtask

	task automatic b_op(input logic wr, input logic [9:0] ad, input logic [31:0] d);
		@(posedge aclk);
		h_go <= 1'b1;
		h_wr <= wr;
		h_addr <= ad;
		h_wd <= d;
		@(posedge aclk);
		h_go <= 1'b0;
		repeat (8) begin
			@(negedge aclk);
			if (h_got) break;
		end
		q = h_data;
	endtask

	task automatic axi_wr(input logic [11:0] ad, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= ad;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [11:0] ad);
		@(posedge aclk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		q = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task conclude;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge aclk) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			conclude;
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		`chk("a_rvalid", 1'b0, a_rvalid)
		`chk("b_rvalid", 1'b0, b_rvalid)
		for (int i = 0; i < 4; i++) begin
			if (row_wp[i]) begin
				b_op(1'b1, row_ad[i], row_d[i]);
				a_op(1'b0, row_ad[i], 32'h0);
			end else begin
				a_op(1'b1, row_ad[i], row_d[i]);
				b_op(1'b0, row_ad[i], 32'h0);
			end
			`chk("cross read", row_d[i], q)
		end
		// Same-cycle write on one port, read on the other: never two writes
		@(posedge aclk);
		h_go <= 1'b1;
		h_wr <= 1'b0;
		h_addr <= 10'h155;
		@(posedge aclk);
		h_go <= 1'b0;
		a_write <= 1'b1;
		a_addr <= 10'h155;
		a_wdata <= 32'h1111_2222;
		@(posedge aclk);
		a_write <= 1'b0;
		repeat (6) @(negedge aclk);
		`chk("mixed read", 32'ha5a5_5a5a, h_data)
		a_op(1'b0, 10'h155, 32'h0);
		`chk("new word", 32'h1111_2222, q)
		// Gated memory: array frozen, reads unanswered
		@(posedge aclk);
		reset_req <= 1'b1;
		a_op(1'b1, 10'h155, 32'hdead_beef);
		a_op(1'b0, 10'h155, 32'h0);
		`chk("gated answer", 1'b0, hit)
		@(posedge aclk);
		reset_req <= 1'b0;
		a_op(1'b0, 10'h155, 32'h0);
		`chk("gated write", 32'h1111_2222, q)
		a_op(1'b1, 10'h2aa, 32'h0bad_f00d);
		a_op(1'b0, 10'h2aa, 32'h0);
		`chk("back to back", 32'h0bad_f00d, q)
		// Edit path writes one byte under the unlock bit
		axi_wr(`OCM_OFS_CTRL, 32'h1);
		axi_wr(`OCM_OFS_DADDR, 32'h554);
		axi_wr(`OCM_OFS_DDATA, 32'h5a);
		`chk("edit resp", `OCM_RESP_OKAY, r)
		axi_rd(`OCM_OFS_DDATA);
		`chk("edit read", 32'h5a, q)
		a_op(1'b0, 10'h155, 32'h0);
		`chk("edited word", 32'h1111_225a, q)
		axi_rd(12'h010);
		`chk("unmapped read", `OCM_RESP_SLVERR, r)
		axi_wr(12'h010, 32'h0);
		`chk("unmapped write", `OCM_RESP_SLVERR, r)
		// Status: path present, gating mirrored, sticky drop cleared by one
		axi_rd(`OCM_OFS_STAT);
		`chk("status idle", 32'h4, q)
		reset_req <= 1'b1;
		axi_rd(`OCM_OFS_STAT);
		`chk("status gated", 32'h5, q)
		reset_req <= 1'b0;
		axi_wr(`OCM_OFS_CTRL, 32'h2);
		axi_wr(`OCM_OFS_DDATA, 32'h77);
		axi_rd(`OCM_OFS_STAT);
		`chk("status drop", 32'h6, q)
		axi_wr(`OCM_OFS_STAT, 32'h2);
		axi_rd(`OCM_OFS_STAT);
		`chk("drop cleared", 32'h4, q)
		// Low byte strobe only: upper address bytes kept
		s_axi_wstrb <= 4'h1;
		axi_wr(`OCM_OFS_DADDR, 32'hfff);
		s_axi_wstrb <= 4'hf;
		axi_rd(`OCM_OFS_DADDR);
		`chk("strobed address", 32'h5ff, q)
		// Mid-run reset: answer in flight dropped, array contents kept
		@(posedge aclk);
		a_read <= 1'b1;
		a_addr <= 10'h155;
		@(posedge aclk);
		a_read <= 1'b0;
		aresetn <= 1'b0;
		repeat (2) @(negedge aclk);
		`chk("reset answer", 1'b0, a_rvalid)
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		`chk("reset awready", 1'b1, s_axi_awready)
		`chk("reset bvalid", 1'b0, s_axi_bvalid)
		axi_rd(`OCM_OFS_CTRL);
		`chk("reset control", 32'h0, q)
		a_op(1'b0, 10'h155, 32'h0);
		`chk("kept word", 32'h1111_225a, q)
		conclude;
	end
endmodule
